// ==== fsc_pkg.sv ====
// Constants and types of the flash self-program controller
package fsc_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // ------------------------------------------------------------
    // Control bit positions
    // ------------------------------------------------------------
    localparam int IRQ_EN_BIT = 7;
    localparam int CS_BUSY_BIT = 6;
    localparam int RSVD_BIT = 5;
    localparam int CS_RDEN_BIT = 4;
    localparam int LFS_BIT = 3;
    localparam int PGWR_BIT = 2;
    localparam int PGER_BIT = 1;
    localparam int SPE_BIT = 0;

    // ------------------------------------------------------------
    // Accepted low five control patterns
    // ------------------------------------------------------------
    localparam logic [4:0] PAT_CS_RDEN = 5'h11;
    localparam logic [4:0] PAT_LFS = 5'h09;
    localparam logic [4:0] PAT_WRITE = 5'h05;
    localparam logic [4:0] PAT_ERASE = 5'h03;
    localparam logic [4:0] PAT_LOAD = 5'h01;

    // ------------------------------------------------------------
    // Command windows in clock cycles
    // ------------------------------------------------------------
    localparam logic [2:0] STORE_WIN = 3'h4;
    localparam logic [1:0] LOAD_WIN = 2'h3;

    // ------------------------------------------------------------
    // Buffer geometry and erased word value
    // ------------------------------------------------------------
    localparam int WORD_BITS = 5;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } fsc_state_t;
endpackage

// ==== fsc_top.sv ====
// Flash self-program controller with Wishbone register slave
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/10ps
// What this block does
// - Erase pattern plus store within four cycles
// - Erase ignores data pair, non-page bits
// - Core stalled during page erase
// - Load pattern stores pair at word field
// - Buffer clears after write, read-enable, reset
// - EEPROM write during loading drops buffer
// - Write pattern plus store programs page
// - Core stalled during page write
// - Address splits into word and page fields
// - Bit zero ignored on buffer load
// - Ready irq: enable, global on, self-program off
// - Concurrent busy bit reads zero
// - Reserved bit five reads zero
// - Load within three cycles returns fuse/lock
// - Write bit clears on done or timeout
// - Erase bit clears on done or timeout
// - Enable opens four-cycle window, held during op
// - Other low five patterns have no effect
// - EEPROM busy blocks programming and fuse reads
// - Programmed bits read zero, unprogrammed one
module fsc_top #(
    parameter int WORD_BITS = fsc_pkg::WORD_BITS
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Core instruction side
    input wire logic STORE_INSTR_I,
    input wire logic LOAD_INSTR_I,
    input wire logic [15:0] ZPTR_I,
    input wire logic [15:0] DATA_PAIR_I,
    input wire logic GIE_I,
    output logic HALT_O,
    output logic IRQ_O,
    output logic LPM_VALID_O,
    output logic [7:0] LPM_DATA_O,
    // EEPROM and fuse status
    input wire logic EEPROM_BUSY_I,
    input wire logic [31:0] FUSE_PROG_I,
    // Flash array side
    input wire logic FLASH_DONE_I,
    input wire logic [WORD_BITS-1:0] FLASH_BUF_ADDR_I,
    output logic [15:0] FLASH_BUF_DATA_O,
    output logic FLASH_ERASE_O,
    output logic FLASH_WRITE_O,
    output logic [14-WORD_BITS:0] FLASH_PAGE_O
);
    localparam int WORDS = 1 << WORD_BITS;
    localparam int PAGE_W = 15 - WORD_BITS;

    typedef struct packed {
        fsc_pkg::fsc_state_t st;
        logic irq_en;
        logic lfs;
        logic pgwr;
        logic pger;
        logic spe;
        logic [2:0] win;
        logic [1:0] lwin;
        logic eep_q;
        logic dirty;
        logic ack;
        logic [31:0] rdat;
        logic lpm_v;
        logic [7:0] lpm_d;
        logic fl_er;
        logic fl_wr;
        logic [PAGE_W-1:0] page;
        logic [WORDS-1:0][15:0] buffer;
    } fsc_regs_t;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Pattern check
    // ------------------------------------------------------------
    function automatic logic pat_ok(input logic [4:0] p);
        pat_ok = (p == fsc_pkg::PAT_CS_RDEN) ||
                 (p == fsc_pkg::PAT_LFS) ||
                 (p == fsc_pkg::PAT_WRITE) ||
                 (p == fsc_pkg::PAT_ERASE) ||
                 (p == fsc_pkg::PAT_LOAD);
    endfunction

    fsc_regs_t r_reg;
    fsc_regs_t r_next;
    logic idle;
    logic wb_req;
    logic ctrl_wr;
    logic store_ok;
    logic load_ok;
    logic eep_rise;
    logic [4:0] wpat;
    logic [7:0] ctrl_rd;

    assign idle = (r_reg.st == fsc_pkg::ST_IDLE);
    assign wb_req = WB_CYC_I && WB_STB_I && !r_reg.ack;
    assign ctrl_wr = wb_req && WB_WE_I && WB_SEL_I[0] &&
                     (WB_ADR_I == fsc_pkg::CTRL_OFS);
    assign wpat = WB_DAT_I[4:0];
    // Window counts only while idle, so a held op keeps its bits
    assign store_ok = STORE_INSTR_I && idle && r_reg.spe &&
                      (r_reg.win != 3'h0) && !EEPROM_BUSY_I;
    assign load_ok = LOAD_INSTR_I && idle && r_reg.lfs &&
                     r_reg.spe && (r_reg.lwin != 2'h0) &&
                     !EEPROM_BUSY_I;
    assign eep_rise = EEPROM_BUSY_I && !r_reg.eep_q;
    // Bits six and five are tied low
    assign ctrl_rd = {r_reg.irq_en, 1'b0, 1'b0, 1'b0,
                      r_reg.lfs, r_reg.pgwr, r_reg.pger, r_reg.spe};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.ack = 1'b0;
        r_next.lpm_v = 1'b0;
        r_next.fl_er = 1'b0;
        r_next.fl_wr = 1'b0;
        r_next.eep_q = EEPROM_BUSY_I;
        if (idle && r_reg.win != 3'h0) begin
            r_next.win = r_reg.win - 3'h1;
        end
        if (r_reg.lwin != 2'h0) begin
            r_next.lwin = r_reg.lwin - 2'h1;
        end
        if (idle && r_reg.win == 3'h1 && !store_ok) begin
            r_next.spe = 1'b0;
            r_next.pgwr = 1'b0;
            r_next.pger = 1'b0;
            r_next.lfs = 1'b0;
        end
        // For erase/write only the page field is latched; word bits and data drop
        if (store_ok) begin
            r_next.win = 3'h0;
            if (r_reg.pger || r_reg.pgwr) begin
                r_next.st = fsc_pkg::ST_BUSY;
                r_next.page = ZPTR_I[15:WORD_BITS+1];
                r_next.fl_er = r_reg.pger;
                r_next.fl_wr = r_reg.pgwr;
            end else begin
                r_next.spe = 1'b0;
                r_next.lfs = 1'b0;
                if (!r_reg.lfs) begin
                    r_next.buffer[ZPTR_I[WORD_BITS:1]] =
                        DATA_PAIR_I;
                    r_next.dirty = 1'b1;
                end
            end
        end
        if (load_ok) begin
            r_next.lpm_v = 1'b1;
            // Fuse inputs mark programmed bits high
            case (ZPTR_I[1:0])
                2'h0: r_next.lpm_d = ~FUSE_PROG_I[7:0];
                2'h1: r_next.lpm_d = ~FUSE_PROG_I[15:8];
                2'h2: r_next.lpm_d = ~FUSE_PROG_I[23:16];
                default: r_next.lpm_d = ~FUSE_PROG_I[31:24];
            endcase
            r_next.lfs = 1'b0;
            r_next.spe = 1'b0;
            r_next.win = 3'h0;
            r_next.lwin = 2'h0;
        end
        if (!idle && FLASH_DONE_I) begin
            r_next.st = fsc_pkg::ST_IDLE;
            r_next.pgwr = 1'b0;
            r_next.pger = 1'b0;
            r_next.spe = 1'b0;
            if (r_reg.pgwr) begin
                r_next.buffer = {WORDS{fsc_pkg::ERASED_WORD}};
                r_next.dirty = 1'b0;
            end
        end
        // Loaded words are lost only if some were loaded
        if (eep_rise && r_reg.dirty) begin
            r_next.buffer = {WORDS{fsc_pkg::ERASED_WORD}};
            r_next.dirty = 1'b0;
        end
        if (wb_req) begin
            r_next.ack = 1'b1;
            if (WB_ADR_I == fsc_pkg::CTRL_OFS) begin
                r_next.rdat = {24'h000000, ctrl_rd};
            end else if (WB_ADR_I == fsc_pkg::STAT_OFS) begin
                r_next.rdat = {29'h00000000, !idle, r_reg.dirty,
                               EEPROM_BUSY_I};
            end else begin
                r_next.rdat = 32'h00000000;
            end
        end
        if (ctrl_wr) begin
            r_next.irq_en = WB_DAT_I[fsc_pkg::IRQ_EN_BIT];
            if (idle && !EEPROM_BUSY_I && pat_ok(wpat)) begin
                r_next.lfs = 1'b0;
                r_next.pgwr = 1'b0;
                r_next.pger = 1'b0;
                r_next.spe = 1'b1;
                r_next.win = fsc_pkg::STORE_WIN;
                r_next.lwin = 2'h0;
                if (wpat == fsc_pkg::PAT_CS_RDEN) begin
                    r_next.buffer = {WORDS{fsc_pkg::ERASED_WORD}};
                    r_next.dirty = 1'b0;
                    r_next.spe = 1'b0;
                    r_next.win = 3'h0;
                end else if (wpat == fsc_pkg::PAT_LFS) begin
                    r_next.lfs = 1'b1;
                    r_next.lwin = fsc_pkg::LOAD_WIN;
                end else if (wpat == fsc_pkg::PAT_WRITE) begin
                    r_next.pgwr = 1'b1;
                end else if (wpat == fsc_pkg::PAT_ERASE) begin
                    r_next.pger = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '{st: fsc_pkg::ST_IDLE,
                       buffer: {WORDS{fsc_pkg::ERASED_WORD}},
                       default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign WB_ACK_O = r_reg.ack;
    assign WB_DAT_O = r_reg.rdat;
    assign HALT_O = !idle;
    assign IRQ_O = r_reg.irq_en && GIE_I && !r_reg.spe;
    assign LPM_VALID_O = r_reg.lpm_v;
    assign LPM_DATA_O = r_reg.lpm_d;
    assign FLASH_ERASE_O = r_reg.fl_er;
    assign FLASH_WRITE_O = r_reg.fl_wr;
    assign FLASH_PAGE_O = r_reg.page;
    assign FLASH_BUF_DATA_O = r_reg.buffer[FLASH_BUF_ADDR_I];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!rst_n);

    a_erase_start: assert property (
        store_ok && r_reg.pger |=> FLASH_ERASE_O && HALT_O)
        else $error("erase did not start");
    a_halt_hold: assert property (
        HALT_O && !FLASH_DONE_I |=> HALT_O && r_reg.spe)
        else $error("stall dropped early");
    a_done_release: assert property (
        HALT_O && FLASH_DONE_I |=> !HALT_O &&
        !r_reg.pgwr && !r_reg.pger && !r_reg.spe)
        else $error("done did not release");
    a_write_clear: assert property (
        HALT_O && FLASH_DONE_I && r_reg.pgwr |=> !r_reg.dirty)
        else $error("buffer kept after write");
    a_window_end: assert property (
        ctrl_wr && idle && !EEPROM_BUSY_I && wpat == fsc_pkg::PAT_WRITE
        ##1 (!STORE_INSTR_I && !ctrl_wr) [*4] |=>
        !r_reg.pgwr && !r_reg.spe)
        else $error("window did not expire");
    a_bad_pattern: assert property (
        ctrl_wr && !pat_ok(wpat) |=> $stable(r_reg.spe) &&
        $stable(r_reg.pgwr) && $stable(r_reg.pger))
        else $error("bad pattern took effect");
    a_eep_block: assert property (
        EEPROM_BUSY_I |=> !FLASH_ERASE_O && !FLASH_WRITE_O &&
        !LPM_VALID_O)
        else $error("work during eeprom write");
    a_reserved_zero: assert property (
        WB_ACK_O |-> WB_DAT_O[6:5] == 2'b00)
        else $error("bits six five not zero");
    a_irq_gate: assert property (
        r_reg.spe |-> !IRQ_O)
        else $error("irq while enabled");
    a_load_store: assert property (
        store_ok && !r_reg.pger && !r_reg.pgwr && !r_reg.lfs |=>
        r_reg.buffer[$past(ZPTR_I[WORD_BITS:1])] ==
        $past(DATA_PAIR_I))
        else $error("word not stored");
    a_eep_drop: assert property (
        eep_rise && r_reg.dirty |=> !r_reg.dirty)
        else $error("buffer kept over eeprom");

    // ------------------------------------------------------------
    // Command start and windows
    // ------------------------------------------------------------
    a_write_start: assert property (
        store_ok && r_reg.pgwr |=> FLASH_WRITE_O && HALT_O)
        else $error("write did not start");
    a_page_latch: assert property (
        store_ok && (r_reg.pger || r_reg.pgwr) |=>
        FLASH_PAGE_O == $past(ZPTR_I[15:WORD_BITS+1]))
        else $error("page not latched");
    // Only a store may start an op; a stray pulse must not stall
    a_halt_start: assert property (
        !HALT_O && !(store_ok && (r_reg.pger || r_reg.pgwr)) |=>
        !HALT_O)
        else $error("stall without store");
    a_spe_held: assert property (
        !idle |-> r_reg.spe)
        else $error("enable dropped during op");
    a_win_expire: assert property (
        idle && r_reg.win == 3'h1 && !STORE_INSTR_I && !ctrl_wr |=>
        !r_reg.pgwr && !r_reg.pger && !r_reg.spe)
        else $error("command bits kept after window");
    a_fuse_byte: assert property (
        load_ok && ZPTR_I[1:0] == 2'h1 |=>
        LPM_VALID_O && LPM_DATA_O == ~$past(FUSE_PROG_I[15:8]))
        else $error("lock byte wrong");
    a_load_gate: assert property (
        !load_ok |=> !LPM_VALID_O)
        else $error("fuse read outside window");
    a_eep_ctrl: assert property (
        ctrl_wr && EEPROM_BUSY_I && !r_reg.spe |=> !r_reg.spe)
        else $error("control taken during eeprom write");

    // ------------------------------------------------------------
    // Buffer and bus
    // ------------------------------------------------------------
    a_erase_data: assert property (
        store_ok && r_reg.pger && !ctrl_wr |=> $stable(r_reg.buffer))
        else $error("erase touched the buffer");
    a_dirty_set: assert property (
        store_ok && !r_reg.pger && !r_reg.pgwr && !r_reg.lfs &&
        !ctrl_wr |=> r_reg.dirty)
        else $error("load not recorded");
    a_rden_clear: assert property (
        ctrl_wr && idle && !EEPROM_BUSY_I &&
        wpat == fsc_pkg::PAT_CS_RDEN |=>
        !r_reg.dirty && FLASH_BUF_DATA_O == fsc_pkg::ERASED_WORD)
        else $error("read enable kept buffer");
    a_ack_answer: assert property (
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not acked");
    a_ack_pulse: assert property (
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_status_read: assert property (
        WB_ACK_O && $past(WB_ADR_I) == fsc_pkg::STAT_OFS |->
        WB_DAT_O[0] == $past(EEPROM_BUSY_I))
        else $error("status busy bit wrong");

    // ------------------------------------------------------------
    // Main scenarios
    // ------------------------------------------------------------
    c_erase: cover property (FLASH_ERASE_O ##[1:20] FLASH_DONE_I);
    c_window: cover property (idle && r_reg.win == 3'h1 && !store_ok);
    c_write: cover property (FLASH_WRITE_O);
    c_fuse: cover property (LPM_VALID_O);
    c_load: cover property (store_ok && !r_reg.pger && !r_reg.pgwr);
endmodule

// ==== fsc_core_model.sv ====
// Core model issuing store and load instructions
`timescale 1ns/10ps
module fsc_core_model (
    // Clock and command from the bench
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic load_i,
    input wire logic [3:0] gap_i,
    input wire logic [15:0] z_i,
    input wire logic [15:0] d_i,
    // Core side of the block
    input wire logic halt_i,
    output logic store_o,
    output logic lpm_o,
    output logic [15:0] zptr_o,
    output logic [15:0] data_o
);
    logic [3:0] cnt_reg = 4'h0;
    logic armed_reg = 1'b0;
    logic kind_reg = 1'b0;
    logic [3:0] left;
    initial begin
        store_o = 1'b0;
        lpm_o = 1'b0;
        zptr_o = 16'h0000;
        data_o = 16'h0000;
    end
    always @(posedge clk_i) begin
        left = go_i ? gap_i : cnt_reg;
        store_o <= 1'b0;
        lpm_o <= 1'b0;
        // Operands only valid with the pulse, else they toggle
        zptr_o <= ~zptr_o;
        data_o <= ~data_o;
        if (go_i) begin
            kind_reg <= load_i;
        end
        // A stalled core issues nothing
        if ((go_i || armed_reg) && !halt_i) begin
            if (left == 4'h0) begin
                armed_reg <= 1'b0;
                store_o <= go_i ? !load_i : !kind_reg;
                lpm_o <= go_i ? load_i : kind_reg;
                zptr_o <= z_i;
                data_o <= d_i;
            end else begin
                armed_reg <= 1'b1;
                cnt_reg <= left - 4'h1;
            end
        end
    end
endmodule

// ==== fsc_tb_top.sv ====
// Testbench of the flash self-program controller
`timescale 1ns/10ps
module fsc_tb_top;
    // ----------------------------------------
    // Signals, design and partner
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] c;
        logic [3:0] g;
        logic e;
        logic w;
    } fsc_row_t;
    logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic gie = 1'b0, ee = 1'b0, go = 1'b0, kind = 1'b0;
    logic done = 1'b0, done_d = 1'b0;
    logic [7:0] adr = 8'h00, ldat, lval;
    logic [3:0] sel = 4'h0, gap = 4'h0, fcnt = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, dout, fuse = 32'h12345678;
    logic [4:0] baddr = 5'h00;
    logic [15:0] z = 16'h0, d = 16'h0, bdat, zp, dp;
    logic [9:0] page;
    logic ack, halt, irq, lv, st, ld, fer, fwr;
    int fail_count = 0, num_checks = 0, n_er = 0, n_wr = 0, n_lv = 0;
    int er0 = 0, wr0 = 0;
    fsc_row_t rows [6] = '{'{8'h03, 4'h0, 1'b1, 1'b0},
        '{8'h03, 4'h2, 1'b0, 1'b0}, '{8'h05, 4'h0, 1'b0, 1'b1},
        '{8'h05, 4'h2, 1'b0, 1'b0}, '{8'h07, 4'h0, 1'b0, 1'b0},
        '{8'h0f, 4'h0, 1'b0, 1'b0}};
    initial forever #10 clk = ~clk;
    fsc_top i_fsc_top (.CORE_CLK_I(clk), .NRST_I(nrst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(dout), .WB_ACK_O(ack),
        .STORE_INSTR_I(st), .LOAD_INSTR_I(ld), .ZPTR_I(zp),
        .DATA_PAIR_I(dp), .GIE_I(gie), .HALT_O(halt), .IRQ_O(irq),
        .LPM_VALID_O(lv), .LPM_DATA_O(ldat), .EEPROM_BUSY_I(ee),
        .FUSE_PROG_I(fuse), .FLASH_DONE_I(done), .FLASH_BUF_ADDR_I(baddr),
        .FLASH_BUF_DATA_O(bdat), .FLASH_ERASE_O(fer), .FLASH_WRITE_O(fwr),
        .FLASH_PAGE_O(page));
    fsc_core_model i_fsc_core_model (.clk_i(clk), .go_i(go), .load_i(kind),
        .gap_i(gap), .z_i(z), .d_i(d), .halt_i(halt), .store_o(st),
        .lpm_o(ld), .zptr_o(zp), .data_o(dp));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] v, output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        sel <= 4'hf;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            end_sim();
        end
    endtask
    task automatic instr(input logic l, input logic [3:0] g);
        go <= 1'b1;
        kind <= l;
        gap <= g;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic load_word;
        wb(1'b1, 8'h00, 32'h01, rdat);
        instr(1'b0, 4'h0);
        repeat (3) @(posedge clk);
    endtask
    // ----------------------------------------
    // Flash array stand-in and monitors
    // ----------------------------------------
    always @(posedge clk) begin
        done <= 1'b0;
        done_d <= done;
        if (fer || fwr) fcnt <= 4'h6;
        else if (fcnt != 4'h0) fcnt <= fcnt - 4'h1;
        if (fcnt == 4'h2) done <= 1'b1;
        n_er <= n_er + fer;
        n_wr <= n_wr + fwr;
        if (done) chk("halt_busy", halt, 1'b1);
        if (done_d) chk("halt_free", halt, 1'b0);
        if (lv) begin
            n_lv <= n_lv + 1;
            lval <= ldat;
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        wb(1'b0, 8'h00, 32'h0, rdat);
        chk("ctrl_rst", rdat, 32'h0);
        chk("halt_rst", halt, 1'b0);
        wb(1'b0, 8'h08, 32'h0, rdat);
        chk("unmapped", rdat, 32'h0);
        $display("test reset done");
        z = 16'hab40;
        foreach (rows[i]) begin
            er0 = n_er;
            wr0 = n_wr;
            wb(1'b1, 8'h00, {24'h0, rows[i].c}, rdat);
            instr(1'b0, rows[i].g);
            repeat (14) @(posedge clk);
            chk("erase", n_er - er0, rows[i].e);
            chk("write", n_wr - wr0, rows[i].w);
            chk("page", page, z[15:6]);
            wb(1'b0, 8'h00, 32'h0, rdat);
            chk("ctrl_clr", rdat, 32'h0);
        end
        $display("test command table done");
        gie <= 1'b1;
        wb(1'b1, 8'h00, 32'he0, rdat);
        @(posedge clk);
        chk("irq_on", irq, 1'b1);
        wb(1'b1, 8'h00, 32'h81, rdat);
        @(posedge clk);
        chk("irq_spe", irq, 1'b0);
        repeat (6) @(posedge clk);
        chk("irq_back", irq, 1'b1);
        wb(1'b0, 8'h00, 32'h0, rdat);
        chk("ctrl_rd", rdat, 32'h80);
        $display("test irq done");
        for (int k = 0; k < 4; k++) begin
            z = 16'(k);
            wb(1'b1, 8'h00, 32'h09, rdat);
            instr(1'b1, 4'h0);
            repeat (3) @(posedge clk);
            chk("fuse", lval, 8'(~fuse[8*k +: 8]));
        end
        wb(1'b1, 8'h00, 32'h09, rdat);
        instr(1'b1, 4'h2);
        repeat (6) @(posedge clk);
        chk("lpm_late", n_lv, 4);
        $display("test fuse done");
        // Each word loaded once per clear, page kept for erase/write
        z = {10'h2a5, 5'd3, 1'b1};
        d = 16'h1234;
        baddr <= 5'd3;
        load_word();
        chk("buf_word", bdat, 16'h1234);
        baddr <= 5'd4;
        @(posedge clk);
        chk("buf_other", bdat, 16'hffff);
        baddr <= 5'd3;
        wb(1'b1, 8'h00, 32'h11, rdat);
        @(posedge clk);
        chk("buf_rden", bdat, 16'hffff);
        load_word();
        ee <= 1'b1;
        repeat (3) @(posedge clk);
        chk("buf_ee", bdat, 16'hffff);
        load_word();
        chk("buf_busy", bdat, 16'hffff);
        wb(1'b0, 8'h04, 32'h0, rdat);
        chk("status", rdat, 32'h1);
        wb(1'b1, 8'h00, 32'h09, rdat);
        instr(1'b1, 4'h0);
        repeat (4) @(posedge clk);
        chk("lpm_busy", n_lv, 4);
        ee <= 1'b0;
        @(posedge clk);
        load_word();
        chk("buf_load", bdat, 16'h1234);
        z = {10'h2a5, 6'h00};
        wr0 = n_wr;
        wb(1'b1, 8'h00, 32'h05, rdat);
        instr(1'b0, 4'h0);
        repeat (14) @(posedge clk);
        chk("pg_write", n_wr - wr0, 1);
        chk("wr_page", page, 10'h2a5);
        chk("buf_done", bdat, 16'hffff);
        $display("test buffer done");
        end_sim();
    end
endmodule
